// >>> logic/cde_descriptor_engine.sv
// descriptor walker and data mover of the crypto engine
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RQ1] walk descriptor list, write status back
// [RQ2] descriptors sit on eight-byte boundaries
// [RQ3] eight words: ctrl, assoc, src, dst, next, upd, len, offset
// [RQ4] control word fields at fixed bit positions
// [RQ5] source pointer is word aligned
// [RQ6] destination pointer is word aligned
// [RQ7] follow full next pointer, any packet
// [RQ8] primitive field is one-hot select set
// [RQ9] direction bit: one encrypts, zero decrypts
// [RQ10] key length codes 128, 192, 256 bits
// [RQ11] key length changes use, not storage
// [RQ12] pass codes single, pipelined, parallel
// [RQ13] chaining mode codes, top code reserved

module cde_descriptor_engine (
    input wire logic sys_clk, // 20 MHz system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [7:0] regAddr, // register byte address
    input wire logic [31:0] regWdata, // register write data
    input wire logic regWr, // register write strobe
    input wire logic regRd, // register read strobe
    output logic [31:0] regRdata, // read data, cycle after strobe
    output cde_pkg::cde_mem_req_t memCmd, // memory request, held to ack
    input wire logic [31:0] memRdata, // memory read data with ack
    input wire logic memAck, // memory request done pulse
    output logic busy, // engine walking the list
    output logic irq // level interrupt
);

    // ----------
    // state
    // ----------
    cde_pkg::cde_state_t state_q;
    cde_pkg::cde_mem_req_t memCmd_q;
    logic [31:0] desc_q [cde_pkg::DESC_WORDS];
    logic [2:0] widx_q;
    logic [31:0] descPtr_q;
    logic [31:0] headPtr_q;
    logic [31:0] srcAddr_q;
    logic [31:0] dstAddr_q;
    logic [14:0] wordsLeft_q;
    cde_pkg::cde_assoc_t assoc_q;
    cde_pkg::cde_assoc_t assocDec;
    logic [31:0] regRdata_q;
    logic busy_q;
    logic [cde_pkg::EV_W-1:0] evSet;
    logic [cde_pkg::EV_W-1:0] evStatus;
    logic [cde_pkg::EV_W-1:0] evMask;

    // ----------
    // descriptor field views
    // ----------
    logic [31:0] ctrlWord;
    logic fetchValid;
    logic assocLoad;
    logic finalDesc;
    logic lastInFrame;
    logic pktIe;
    logic descIe;
    logic [15:0] bufLen;
    logic [2:0] cryptoMode;
    logic [14:0] lenWords;
    logic [31:0] descBase;
    logic [31:0] updAddr;
    logic [31:0] srcWordAddr;
    logic [31:0] dstWordAddr;
    logic startReq;
    logic [16:0] lenRound;

    always_comb begin
        // [RQ4] control word bit positions
        ctrlWord = desc_q[cde_pkg::W_CTRL];
        assocLoad = ctrlWord[cde_pkg::CW_ASSOC_EN];
        finalDesc = ctrlWord[cde_pkg::CW_FINAL];
        lastInFrame = ctrlWord[cde_pkg::CW_LAST_IN_FRAME_FLAG];
        pktIe = ctrlWord[cde_pkg::CW_PKT_IE];
        descIe = ctrlWord[cde_pkg::CW_DESC_IE];
        bufLen = ctrlWord[cde_pkg::CW_LEN_HI:0];
        cryptoMode = ctrlWord[cde_pkg::CW_MODE_HI:cde_pkg::CW_MODE_LO];
        // valid bit checked on the first word as it arrives
        fetchValid = memRdata[cde_pkg::CW_VALID];
        // partial last word still moves a whole word
        lenRound = {1'b0, bufLen} + 17'h00003;
        lenWords = lenRound[16:2];
        // [RQ2] low three pointer bits taken as zero
        descBase = {descPtr_q[31:3], 3'b000};
        updAddr = (desc_q[cde_pkg::W_UPD] == 32'h0000_0000) ? descBase
            : {desc_q[cde_pkg::W_UPD][31:2], 2'b00};
        // [RQ5] source word aligned
        srcWordAddr = {desc_q[cde_pkg::W_SRC][31:2], 2'b00};
        // [RQ6] destination word aligned
        dstWordAddr = {desc_q[cde_pkg::W_DST][31:2], 2'b00};
        startReq = regWr && (regAddr == cde_pkg::REG_CTRL) && regWdata[cde_pkg::CTRL_GO];
    end

    // ----------
    // association word decode, straight off the memory data
    // ----------
    cde_assoc_decode u_decode (
        .assocWord(memRdata),
        .cfg(assocDec)
    );

    // ----------
    // sequencer and memory requests
    // ----------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= cde_pkg::ST_IDLE;
            memCmd_q <= '0;
            widx_q <= 3'h0;
            descPtr_q <= 32'h0000_0000;
            srcAddr_q <= 32'h0000_0000;
            dstAddr_q <= 32'h0000_0000;
            wordsLeft_q <= 15'h0000;
        end else begin
            unique case (state_q)
                cde_pkg::ST_IDLE: begin
                    // a go outside idle is ignored
                    if (startReq) begin
                        descPtr_q <= headPtr_q;
                        widx_q <= 3'h0;
                        memCmd_q <= '{req: 1'b1, we: 1'b0,
                            addr: {headPtr_q[31:3], 3'b000}, wdata: 32'h0000_0000};
                        state_q <= cde_pkg::ST_FETCH;
                    end
                end
                cde_pkg::ST_FETCH: begin
                    if (memAck) begin
                        if ((widx_q == cde_pkg::W_CTRL) && !fetchValid) begin
                            // empty slot ends the walk
                            memCmd_q.req <= 1'b0;
                            state_q <= cde_pkg::ST_IDLE;
                        end else if (widx_q == cde_pkg::W_OFF) begin
                            srcAddr_q <= srcWordAddr;
                            dstAddr_q <= dstWordAddr;
                            wordsLeft_q <= lenWords;
                            if (assocLoad) begin
                                memCmd_q.addr <= {desc_q[cde_pkg::W_ASSOC][31:2], 2'b00};
                                state_q <= cde_pkg::ST_ASSOC;
                            end else if (lenWords == 15'h0000) begin
                                memCmd_q <= '{req: 1'b1, we: 1'b1, addr: updAddr,
                                    wdata: ctrlWord & ~(32'h1 << cde_pkg::CW_VALID)};
                                state_q <= cde_pkg::ST_UPDATE;
                            end else begin
                                memCmd_q.addr <= srcWordAddr;
                                state_q <= cde_pkg::ST_READ;
                            end
                        end else begin
                            // [RQ3] eight consecutive words
                            widx_q <= widx_q + 3'h1;
                            memCmd_q.addr <= memCmd_q.addr + cde_pkg::WORD_STEP;
                        end
                    end
                end
                cde_pkg::ST_ASSOC: begin
                    if (memAck) begin
                        if (assocDec.bad) begin
                            // reserved codes stop the walk, descriptor left valid
                            memCmd_q.req <= 1'b0;
                            state_q <= cde_pkg::ST_IDLE;
                        end else if (wordsLeft_q == 15'h0000) begin
                            memCmd_q <= '{req: 1'b1, we: 1'b1, addr: updAddr,
                                wdata: ctrlWord & ~(32'h1 << cde_pkg::CW_VALID)};
                            state_q <= cde_pkg::ST_UPDATE;
                        end else begin
                            memCmd_q.addr <= srcAddr_q;
                            state_q <= cde_pkg::ST_READ;
                        end
                    end
                end
                cde_pkg::ST_READ: begin
                    if (memAck) begin
                        memCmd_q <= '{req: 1'b1, we: 1'b1, addr: dstAddr_q, wdata: memRdata};
                        srcAddr_q <= srcAddr_q + cde_pkg::WORD_STEP;
                        state_q <= cde_pkg::ST_WRITE;
                    end
                end
                cde_pkg::ST_WRITE: begin
                    if (memAck) begin
                        dstAddr_q <= dstAddr_q + cde_pkg::WORD_STEP;
                        wordsLeft_q <= wordsLeft_q - 15'h0001;
                        if (wordsLeft_q == 15'h0001) begin
                            // [RQ1] hand the descriptor back to software
                            memCmd_q <= '{req: 1'b1, we: 1'b1, addr: updAddr,
                                wdata: ctrlWord & ~(32'h1 << cde_pkg::CW_VALID)};
                            state_q <= cde_pkg::ST_UPDATE;
                        end else begin
                            memCmd_q <= '{req: 1'b1, we: 1'b0, addr: srcAddr_q,
                                wdata: 32'h0000_0000};
                            state_q <= cde_pkg::ST_READ;
                        end
                    end
                end
                cde_pkg::ST_UPDATE: begin
                    if (memAck) begin
                        if (finalDesc) begin
                            memCmd_q.req <= 1'b0;
                            state_q <= cde_pkg::ST_IDLE;
                        end else begin
                            // [RQ7] full 32-bit next pointer followed
                            descPtr_q <= desc_q[cde_pkg::W_NEXT];
                            widx_q <= 3'h0;
                            memCmd_q <= '{req: 1'b1, we: 1'b0,
                                addr: {desc_q[cde_pkg::W_NEXT][31:3], 3'b000},
                                wdata: 32'h0000_0000};
                            state_q <= cde_pkg::ST_FETCH;
                        end
                    end
                end
                default: begin
                    memCmd_q.req <= 1'b0;
                    state_q <= cde_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------
    // descriptor word capture
    // ----------
    // [RQ3] words stored by index as fetched
    always_ff @(posedge sys_clk) begin
        if (state_q == cde_pkg::ST_FETCH && memAck) begin
            desc_q[widx_q] <= memRdata;
        end
    end

    // ----------
    // latched association settings
    // ----------
    // [RQ8] settings kept for the following descriptors
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            assoc_q <= '0;
        end else if (state_q == cde_pkg::ST_ASSOC && memAck) begin
            assoc_q <= assocDec;
        end
    end

    // ----------
    // events
    // ----------
    always_comb begin
        evSet = '0;
        if (state_q == cde_pkg::ST_UPDATE && memAck) begin
            evSet[cde_pkg::EV_DESC] = descIe;
            evSet[cde_pkg::EV_PKT] = pktIe && lastInFrame;
            evSet[cde_pkg::EV_END] = finalDesc;
        end
        if (state_q == cde_pkg::ST_FETCH && memAck && widx_q == cde_pkg::W_CTRL) begin
            evSet[cde_pkg::EV_END] = !fetchValid;
        end
        if (state_q == cde_pkg::ST_ASSOC && memAck) begin
            evSet[cde_pkg::EV_ERR] = assocDec.bad;
        end
    end

    cde_irq_ctrl u_irq (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .evSet(evSet),
        .rdClear(regRd && (regAddr == cde_pkg::REG_INT_STAT)),
        .maskWr(regWr && (regAddr == cde_pkg::REG_INT_MASK)),
        .maskData(regWdata[cde_pkg::EV_W-1:0]),
        .evStatus(evStatus),
        .evMask(evMask),
        .irqLevel(irq)
    );

    // ----------
    // register writes
    // ----------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            headPtr_q <= cde_pkg::HEAD_RST;
        end else if (regWr && regAddr == cde_pkg::REG_HEAD) begin
            headPtr_q <= regWdata;
        end
    end

    // ----------
    // register reads, one cycle later, unmapped reads zero
    // ----------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regRdata_q <= 32'h0000_0000;
        end else if (regRd) begin
            case (regAddr)
                cde_pkg::REG_HEAD: regRdata_q <= headPtr_q;
                cde_pkg::REG_STATUS: regRdata_q <= {21'h000000, cryptoMode, 5'h00, state_q};
                cde_pkg::REG_CUR: regRdata_q <= descPtr_q;
                cde_pkg::REG_INT_STAT: regRdata_q <= {28'h0000000, evStatus};
                cde_pkg::REG_INT_MASK: regRdata_q <= {28'h0000000, evMask};
                cde_pkg::REG_ASSOC: regRdata_q <= {7'h00, assoc_q};
                default: regRdata_q <= 32'h0000_0000;
            endcase
        end else begin
            regRdata_q <= 32'h0000_0000;
        end
    end

    // ----------
    // busy flag, trails the state by one cycle
    // ----------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q != cde_pkg::ST_IDLE);
        end
    end

    assign regRdata = regRdata_q;
    assign memCmd = memCmd_q;
    assign busy = busy_q;

endmodule : cde_descriptor_engine

`default_nettype wire

// >>> inc/cde_pkg.sv
// shared constants and carrier types for the crypto descriptor engine
`default_nettype none

package cde_pkg;

    // -----------------------------------------------------------------
    // descriptor layout: eight words, index order fixed
    // -----------------------------------------------------------------
    localparam logic [2:0] W_CTRL = 3'h0;
    localparam logic [2:0] W_ASSOC = 3'h1;
    localparam logic [2:0] W_SRC = 3'h2;
    localparam logic [2:0] W_DST = 3'h3;
    localparam logic [2:0] W_NEXT = 3'h4;
    localparam logic [2:0] W_UPD = 3'h5;
    localparam logic [2:0] W_MSG = 3'h6;
    localparam logic [2:0] W_OFF = 3'h7;
    localparam int DESC_WORDS = 8;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    // control word fields
    localparam int CW_VALID = 31;
    localparam int CW_MODE_HI = 29;
    localparam int CW_MODE_LO = 27;
    localparam int CW_ASSOC_EN = 22;
    localparam int CW_FINAL = 19;
    localparam int CW_LAST_IN_FRAME_FLAG = 18;
    localparam int CW_PKT_IE = 17;
    localparam int CW_DESC_IE = 16;
    localparam int CW_LEN_HI = 15;

    // association control word fields
    localparam int AC_PRIM_HI = 16;
    localparam int AC_PRIM_LO = 10;
    localparam int AC_DIR = 9;
    localparam int AC_KEY_HI = 8;
    localparam int AC_KEY_LO = 7;
    localparam int AC_PASS_HI = 6;
    localparam int AC_PASS_LO = 4;
    localparam int AC_CHAIN_HI = 3;
    localparam logic [3:0] CHAIN_RSVD = 4'hF;
    localparam logic [8:0] KEY_BITS_128 = 9'h080;
    localparam logic [8:0] KEY_BITS_192 = 9'h0C0;
    localparam logic [8:0] KEY_BITS_256 = 9'h100;

    typedef enum logic [2:0] {
        PASS_SINGLE = 3'b000,
        PASS_PIPE = 3'b101,
        PASS_PARALLEL = 3'b111
    } cde_pass_t;

    // -----------------------------------------------------------------
    // register map and fields
    // -----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HEAD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CUR = 8'h0C;
    localparam logic [7:0] REG_INT_STAT = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;
    localparam logic [7:0] REG_ASSOC = 8'h18;
    localparam int CTRL_GO = 0;
    localparam logic [31:0] HEAD_RST = 32'h0000_0000;
    localparam logic [3:0] MASK_RST = 4'h0;

    // event bits, same layout in status and mask
    localparam int EV_DESC = 0;
    localparam int EV_PKT = 1;
    localparam int EV_END = 2;
    localparam int EV_ERR = 3;
    localparam int EV_W = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_ASSOC = 3'b010,
        ST_READ = 3'b011,
        ST_WRITE = 3'b100,
        ST_UPDATE = 3'b101
    } cde_state_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cde_mem_req_t;

    typedef struct packed {
        logic bad;
        logic [6:0] prim;
        logic encrypt;
        logic [8:0] keyBits;
        logic [2:0] pass;
        logic [3:0] chain;
    } cde_assoc_t;

endpackage : cde_pkg

`default_nettype wire

// >>> logic/cde_assoc_decode.sv
// decoder for the security-association control word
`timescale 1ns/1ps
`default_nettype none

module cde_assoc_decode (
    input wire logic [31:0] assocWord, // raw association control word
    output cde_pkg::cde_assoc_t cfg // decoded fields and error flag
);

    logic [1:0] keySel;
    logic passOk;

    always_comb begin
        keySel = assocWord[cde_pkg::AC_KEY_HI:cde_pkg::AC_KEY_LO];
        // [RQ8] one-hot primitive selects
        cfg.prim = assocWord[cde_pkg::AC_PRIM_HI:cde_pkg::AC_PRIM_LO];
        // [RQ9] direction bit
        cfg.encrypt = assocWord[cde_pkg::AC_DIR];
        // [RQ10] key length code
        // [RQ11] only a used-bit count, storage unchanged
        case (keySel)
            2'b00: cfg.keyBits = cde_pkg::KEY_BITS_128;
            2'b01: cfg.keyBits = cde_pkg::KEY_BITS_192;
            2'b10: cfg.keyBits = cde_pkg::KEY_BITS_256;
            default: cfg.keyBits = cde_pkg::KEY_BITS_128;
        endcase
        // [RQ12] pass combination codes
        cfg.pass = assocWord[cde_pkg::AC_PASS_HI:cde_pkg::AC_PASS_LO];
        passOk = (cfg.pass == cde_pkg::PASS_SINGLE) || (cfg.pass == cde_pkg::PASS_PIPE)
            || (cfg.pass == cde_pkg::PASS_PARALLEL);
        // [RQ13] chaining mode, top code reserved
        cfg.chain = assocWord[cde_pkg::AC_CHAIN_HI:0];
        cfg.bad = !$onehot(cfg.prim) || (keySel == 2'b11) || !passOk
            || (cfg.chain == cde_pkg::CHAIN_RSVD);
    end

endmodule : cde_assoc_decode

`default_nettype wire

// >>> logic/cde_irq_ctrl.sv
// sticky event flags, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none

module cde_irq_ctrl (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [cde_pkg::EV_W-1:0] evSet, // one-cycle event pulses
    input wire logic rdClear, // status register read
    input wire logic maskWr, // mask register write
    input wire logic [cde_pkg::EV_W-1:0] maskData, // new mask
    output logic [cde_pkg::EV_W-1:0] evStatus, // sticky flags
    output logic [cde_pkg::EV_W-1:0] evMask, // mask bits
    output logic irqLevel // unmasked flag pending
);

    logic [cde_pkg::EV_W-1:0] status_q;
    logic [cde_pkg::EV_W-1:0] status_d;
    logic [cde_pkg::EV_W-1:0] mask_q;
    logic [cde_pkg::EV_W-1:0] mask_d;
    logic irq_q;

    // set wins over the read that clears
    always_comb begin
        status_d = (rdClear ? '0 : status_q) | evSet;
        mask_d = maskWr ? maskData : mask_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_q <= '0;
            mask_q <= cde_pkg::MASK_RST;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= |(status_d & mask_d);
        end
    end

    assign evStatus = status_q;
    assign evMask = mask_q;
    assign irqLevel = irq_q;

endmodule : cde_irq_ctrl

`default_nettype wire

// >>> dv/cde_mem_model.sv
// behavioural system memory on the engine's request port
`timescale 1ns/1ps
`default_nettype none
module cde_mem_model (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic slow, // two wait cycles per access
    input wire cde_pkg::cde_mem_req_t memCmd, // engine request
    output logic [31:0] memRdata, // read data with ack
    output logic memAck // one-cycle completion
);
    logic [31:0] mem [256];
    logic [1:0] waitQ;
    always @(posedge sys_clk) begin
        memAck <= 1'b0;
        // released data toggles so a stale read never matches
        memRdata <= ~memRdata;
        if (!rst_n) begin
            waitQ <= 2'h0;
            memRdata <= 32'h5A5A_A5A5;
        end else if (memCmd.req && !memAck) begin
            if (waitQ == {slow, 1'b0}) begin
                memAck <= 1'b1;
                waitQ <= 2'h0;
                if (memCmd.we) begin
                    mem[memCmd.addr[9:2]] <= memCmd.wdata;
                end else begin
                    memRdata <= mem[memCmd.addr[9:2]];
                end
            end else begin
                waitQ <= waitQ + 2'h1;
            end
        end
    end
endmodule : cde_mem_model
`default_nettype wire

// >>> dv/cde_assertions.sv
// port checks of the descriptor engine
`timescale 1ns/1ps
`default_nettype none
module cde_checker (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [7:0] regAddr, // register address
    input wire logic [31:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [31:0] regRdata, // read data
    input wire cde_pkg::cde_mem_req_t memCmd, // memory request
    input wire logic [31:0] memRdata, // memory data
    input wire logic memAck, // memory ack
    input wire logic busy, // walking
    input wire logic irq // interrupt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_go;
        regWr && regAddr == cde_pkg::REG_CTRL && regWdata[cde_pkg::CTRL_GO] && !busy;
    endsequence
    property p_rdZero; !regRd |=> regRdata == 32'h0; endproperty
    a_rdZero: assert property (p_rdZero)
        else $error("stray read data");
    property p_hold; memCmd.req && !memAck |=> $stable(memCmd); endproperty
    a_hold: assert property (p_hold)
        else $error("request moved early");
    property p_aligned; memCmd.req |-> memCmd.addr[1:0] == 2'h0; endproperty
    a_aligned: assert property (p_aligned)
        else $error("unaligned address");
    property p_goFetch; s_go |=> memCmd.req && !memCmd.we && memCmd.addr[2:0] == 3'h0; endproperty
    a_goFetch: assert property (p_goFetch)
        else $error("bad first fetch");
    property p_advance;
        memAck |=> !memCmd.req || memCmd.addr != $past(memCmd.addr) || memCmd.we != $past(memCmd.we);
    endproperty
    a_advance: assert property (p_advance)
        else $error("request not advanced");
    property p_busyRise; $rose(busy) |-> $past(regWr, 2) && $past(regAddr, 2) == cde_pkg::REG_CTRL; endproperty
    a_busyRise: assert property (p_busyRise)
        else $error("walk without go");
    property p_irqFall; $fell(irq) |-> $past(regRd) || $past(regWr); endproperty
    a_irqFall: assert property (p_irqFall)
        else $error("irq fell without access");
    property p_irqRise; $rose(irq) |-> $past(busy) || $past(regWr); endproperty
    a_irqRise: assert property (p_irqRise)
        else $error("irq rose while idle");
    property p_memIdle; !busy && !$past(busy) && !$past(regWr) |-> !memCmd.req; endproperty
    a_memIdle: assert property (p_memIdle)
        else $error("request while idle");
endmodule : cde_checker
bind cde_descriptor_engine cde_checker i_chk (.sys_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .memCmd, .memRdata, .memAck, .busy, .irq);
`default_nettype wire

// >>> dv/test_crypto_descriptor_engine.sv
// self-checking bench of the crypto descriptor engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_crypto_descriptor_engine;
    logic sys_clk, rst_n, regWr, regRd, memAck, busy, irq, slow;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, memRdata, v;
    cde_pkg::cde_mem_req_t memCmd;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    typedef struct packed {logic [31:0] word; logic [8:0] key; logic [3:0] ev;} cde_row_t;
    // association words: prim[16:10] dir[9] key[8:7] pass[6:4] chain[3:0]
    cde_row_t rows [7] = '{{32'h0000_1209, cde_pkg::KEY_BITS_128, 4'h5},
        {32'h0000_04D0, cde_pkg::KEY_BITS_192, 4'h5}, {32'h0001_037E, cde_pkg::KEY_BITS_256, 4'h5},
        {32'h0000_1A08, 9'h000, 4'h8}, {32'h0000_1388, 9'h000, 4'h8},
        {32'h0000_1238, 9'h000, 4'h8}, {32'h0000_120F, 9'h000, 4'h8}};
    cde_descriptor_engine i_dut (.sys_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .memCmd,
        .memRdata, .memAck, .busy, .irq);
    cde_mem_model i_mem (.sys_clk, .rst_n, .slow, .memCmd, .memRdata, .memAck);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask : reset
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
        @(posedge sys_clk);
    endtask : rd
    // busy rises one edge after the go is taken
    task automatic walk(input logic [31:0] head);
        int k;
        wr(cde_pkg::REG_HEAD, head);
        wr(cde_pkg::REG_CTRL, 32'h0000_0001);
        @(posedge sys_clk);
        k = 0;
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge sys_clk);
            k++;
        end
        `CHK(busy, 1'b0)
    endtask : walk
    task automatic desc(input int b, input logic [31:0] c, s, d, n);
        i_mem.mem[b] = c;
        i_mem.mem[b + 1] = 32'h0000_0180;
        i_mem.mem[b + 2] = s;
        i_mem.mem[b + 3] = d;
        i_mem.mem[b + 4] = n;
        for (int i = 5; i < 8; i++) i_mem.mem[b + i] = 32'h0;
    endtask : desc
    initial begin
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        slow = 1'b0;
        reset();
        // descriptors sit on eight-byte boundaries, buffers on words
        foreach (rows[r]) begin
            desc(64, 32'h8049_0004, 32'h0000_01A0, 32'h0000_01C0, 32'h0);
            i_mem.mem[96] = rows[r].word;
            i_mem.mem[104] = 32'hA5C3_0000 + r;
            i_mem.mem[112] = 32'h0;
            walk(32'h0000_0100);
            rd(cde_pkg::REG_INT_STAT, v);
            `CHK(v, {28'h0, rows[r].ev})
            `CHK(i_mem.mem[64], rows[r].ev[3] ? 32'h8049_0004 : 32'h0049_0004)
            if (rows[r].ev[3] === 1'b0) begin
                rd(cde_pkg::REG_ASSOC, v);
                `CHK(v, {8'h00, rows[r].word[16:9], rows[r].key, rows[r].word[6:0]})
                `CHK(i_mem.mem[112], i_mem.mem[104])
            end
            $display("row %0d done", r);
        end
        reset();
        rd(cde_pkg::REG_HEAD, v);
        `CHK(v, cde_pkg::HEAD_RST)
        rd(cde_pkg::REG_INT_MASK, v);
        `CHK(v, 32'h0)
        rd(8'h1C, v);
        `CHK(v, 32'h0)
        $display("reset test done");
        slow <= 1'b1;
        wr(cde_pkg::REG_INT_MASK, 32'h0000_0002);
        desc(64, 32'h8040_0004, 32'h0000_01A0, 32'h0000_01C0, 32'h0000_0140);
        desc(80, 32'hA80E_0008, 32'h0000_01A0, 32'h0000_01E0, 32'h0);
        i_mem.mem[96] = rows[0].word;
        i_mem.mem[105] = 32'h5A5A_0001;
        walk(32'h0000_0100);
        `CHK(i_mem.mem[120], i_mem.mem[104])
        `CHK(i_mem.mem[121], i_mem.mem[105])
        `CHK(i_mem.mem[80], 32'h280E_0008)
        `CHK(irq, 1'b1)
        rd(cde_pkg::REG_STATUS, v);
        `CHK(v, 32'h0000_0500)
        rd(cde_pkg::REG_INT_STAT, v);
        `CHK(v, 32'h0000_0006)
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        $display("chain test done");
        i_mem.mem[128] = 32'h0;
        walk(32'h0000_0200);
        rd(cde_pkg::REG_INT_STAT, v);
        `CHK(v, 32'h0000_0004)
        $display("invalid descriptor test done");
        summarize();
    end
endmodule : test_crypto_descriptor_engine
`default_nettype wire
